// ==== tws_pkg.sv ====
// Package with constants and types for the two-wire EEPROM write slave.
package tws_pkg;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int unsigned CLK_MHZ = 125;
  localparam int unsigned PROG_TIME_MS = 5;
  localparam int unsigned PROG_CYCLES = PROG_TIME_MS * 1000 * CLK_MHZ;
  localparam int unsigned GLITCH_NS = 50;
  localparam int unsigned GLITCH_CYCLES = (GLITCH_NS * CLK_MHZ + 999) / 1000;

  // ==========================================================================
  // Address word layout
  // ==========================================================================
  localparam logic [3:0] DEV_TYPE_CODE = 4'ha;
  localparam int unsigned WORD_BITS = 8;
  localparam int unsigned ADDR_BITS = 15;
  localparam int unsigned PAGE_BITS = 6;
  localparam logic [14:0] ADDR_RST = 15'h0000;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_DEV = 6'h02,
    ST_ADDR_HI = 6'h04,
    ST_ADDR_LO = 6'h08,
    ST_DATA = 6'h10,
    ST_READ = 6'h20
  } tws_state_t;

  typedef struct packed {
    logic start;
    logic stop;
    logic rise;
    logic fall;
  } tws_evt_t;

  typedef struct packed {
    logic valid;
    logic [14:0] addr;
    logic [7:0] data;
  } tws_wr_t;

endpackage : tws_pkg

// ==== tws_line_sync.sv ====
// Synchroniser, glitch filter and event detector for the serial pins.
`timescale 1ns/1ps

module tws_line_sync #(
  parameter int unsigned FILT = tws_pkg::GLITCH_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda,
  output tws_pkg::tws_evt_t o_evt
);

  initial begin
    if (FILT < 1 || FILT > 15) $error("FILT out of range");
  end

  // ==========================================================================
  // Two-stage synchronisers
  // ==========================================================================
  logic [1:0] scl_meta_r;
  logic [1:0] sda_meta_r;
  logic [3:0] scl_cnt_r;
  logic [3:0] sda_cnt_r;
  logic scl_r;
  logic sda_r;
  logic scl_nxt;
  logic sda_nxt;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      scl_meta_r <= 2'h3;
      sda_meta_r <= 2'h3;
    end else begin
      scl_meta_r <= {scl_meta_r[0], i_scl};
      sda_meta_r <= {sda_meta_r[0], i_sda};
    end
  end

  // ==========================================================================
  // Filters: a level must hold FILT+1 cycles before it is accepted
  // ==========================================================================
  assign scl_nxt = (scl_cnt_r == 4'(FILT)) ? scl_meta_r[1] : scl_r;
  assign sda_nxt = (sda_cnt_r == 4'(FILT)) ? sda_meta_r[1] : sda_r;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      scl_cnt_r <= 4'h0;
      sda_cnt_r <= 4'h0;
      scl_r <= 1'b1;
      sda_r <= 1'b1;
      o_evt <= '0;
    end else begin
      scl_cnt_r <= (scl_meta_r[1] == scl_r) ? 4'h0 : scl_cnt_r + 4'h1;
      sda_cnt_r <= (sda_meta_r[1] == sda_r) ? 4'h0 : sda_cnt_r + 4'h1;
      scl_r <= scl_nxt;
      sda_r <= sda_nxt;
      o_evt.start <= scl_r && scl_nxt && sda_r && !sda_nxt;
      o_evt.stop <= scl_r && scl_nxt && !sda_r && sda_nxt;
      o_evt.rise <= !scl_r && scl_nxt;
      o_evt.fall <= scl_r && !scl_nxt;
    end
  end

  assign o_scl = scl_r;
  assign o_sda = sda_r;

endmodule : tws_line_sync

// ==== tws_slave.sv ====
// Two-wire EEPROM target: addressing, byte and page write, program timer.
// ============================================================================
// How it works
// - Data changing while clock high is start/stop
// - Falling data, clock high, starts a command
// - Rising data, clock high, stops anywhere
// - Stop after a read returns to standby
// - Eight bits MSB first, ack on ninth
// - Standby at reset and after stop; after a write stop, only once the program timer ends
// - Start, nine clocks, start, stop resets protocol
// - Device word top nibble must be 1010
// - Next three bits match chip select pins
// - Low bit: one read, zero write
// - Ack on match, else release until start
// - Write protect high blocks all writes
// - Byte write: two address bytes, data, stop
// - Self-timed program after stop, inputs ignored
// - Program time counted from stop
// - Page write up to 64 bytes
// - Only low six address bits increment
// - In-page address wraps, overwriting earlier bytes
// - No address ack while programming
// - Sample on clock rise, drive after fall
// - Fifteen-bit word address, top bit ignored
// ============================================================================
`timescale 1ns/1ps

module tws_slave #(
  parameter int unsigned PROG_CYCLES = tws_pkg::PROG_CYCLES,
  parameter int unsigned PAGE_BYTES = 64
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_oe,
  output logic o_sda_out,
  input wire logic i_chip_select_pin_high,
  input wire logic i_chip_select_pin_mid,
  input wire logic i_chip_select_pin_low,
  input wire logic i_write_protect,
  output tws_pkg::tws_wr_t o_mem_wr,
  output logic o_busy,
  output logic o_standby
);

  initial begin
    if (PROG_CYCLES < 1) $error("PROG_CYCLES must be positive");
    if (PAGE_BYTES != (1 << tws_pkg::PAGE_BITS)) $error("PAGE_BYTES bad");
  end

  // ==========================================================================
  // Pin conditioning
  // ==========================================================================
  logic scl_s;
  logic sda_s;
  tws_pkg::tws_evt_t evt;
  logic [2:0] cs_meta_r;
  logic [2:0] cs_r;
  logic [1:0] wp_meta_r;
  logic wp_r;

  tws_line_sync u_sync (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_scl(i_scl),
    .i_sda(i_sda),
    .o_scl(scl_s),
    .o_sda(sda_s),
    .o_evt(evt)
  );

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cs_meta_r <= 3'h0;
      cs_r <= 3'h0;
      wp_meta_r <= 2'h0;
      wp_r <= 1'b0;
    end else begin
      cs_meta_r <= {i_chip_select_pin_high, i_chip_select_pin_mid,
                    i_chip_select_pin_low};
      cs_r <= cs_meta_r;
      wp_meta_r <= {wp_meta_r[0], i_write_protect};
      wp_r <= wp_meta_r[1];
    end
  end

  // ==========================================================================
  // State and shift registers
  // ==========================================================================
  tws_pkg::tws_state_t state_r;
  tws_pkg::tws_state_t state_nxt;
  logic [7:0] shift_r;
  logic [3:0] bit_r;
  logic ack_phase_r;
  logic ack_ok_r;
  logic [14:0] addr_r;
  logic wrote_r;
  logic [31:0] prog_cnt_r;
  logic busy_r;
  logic sda_oe_r;
  logic standby_r;
  logic sda_out_r;
  tws_pkg::tws_wr_t wr_r;

  // ==========================================================================
  // Decoding
  // ==========================================================================
  wire [7:0] word_in = {shift_r[6:0], sda_s};
  wire word_done = evt.rise && !ack_phase_r && (bit_r == 4'h7);
  wire dev_match = (word_in[7:4] == tws_pkg::DEV_TYPE_CODE)
                   && (word_in[3:1] == cs_r);
  wire is_read = word_in[0];
  wire dev_ack = dev_match && !busy_r;
  wire ack_end = evt.fall && ack_phase_r && (bit_r == 4'h1);
  wire [5:0] page_inc = addr_r[5:0] + 6'h01;
  wire [14:0] addr_next = {addr_r[14:6], page_inc};
  wire prog_done = busy_r && (prog_cnt_r == PROG_CYCLES - 1);

  // ==========================================================================
  // Next state on each received word
  // ==========================================================================
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      tws_pkg::ST_IDLE: begin
        state_nxt = tws_pkg::ST_IDLE;
      end
      tws_pkg::ST_DEV: begin
        if (!dev_ack) begin
          state_nxt = tws_pkg::ST_IDLE;
        end else if (is_read) begin
          state_nxt = tws_pkg::ST_READ;
        end else begin
          state_nxt = tws_pkg::ST_ADDR_HI;
        end
      end
      tws_pkg::ST_ADDR_HI: begin
        state_nxt = tws_pkg::ST_ADDR_LO;
      end
      tws_pkg::ST_ADDR_LO: begin
        state_nxt = tws_pkg::ST_DATA;
      end
      tws_pkg::ST_DATA: begin
        state_nxt = tws_pkg::ST_DATA;
      end
      tws_pkg::ST_READ: begin
        state_nxt = tws_pkg::ST_READ;
      end
      default: begin
        state_nxt = tws_pkg::ST_IDLE;
      end
    endcase
  end

  // ==========================================================================
  // Protocol engine
  // ==========================================================================
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_r <= tws_pkg::ST_IDLE;
      shift_r <= 8'h00;
      bit_r <= 4'h0;
      ack_phase_r <= 1'b0;
      ack_ok_r <= 1'b0;
      addr_r <= tws_pkg::ADDR_RST;
      wrote_r <= 1'b0;
    end else if (evt.start) begin
      state_r <= tws_pkg::ST_DEV;
      bit_r <= 4'h0;
      ack_phase_r <= 1'b0;
      ack_ok_r <= 1'b0;
      wrote_r <= 1'b0;
    end else if (evt.stop) begin
      state_r <= tws_pkg::ST_IDLE;
      bit_r <= 4'h0;
      ack_phase_r <= 1'b0;
      ack_ok_r <= 1'b0;
    end else if (state_r != tws_pkg::ST_IDLE &&
                 (state_r != tws_pkg::ST_READ || ack_phase_r)) begin
      if (evt.rise && !ack_phase_r) begin
        shift_r <= word_in;
        bit_r <= bit_r + 4'h1;
      end
      if (word_done) begin
        state_r <= state_nxt;
        ack_phase_r <= 1'b1;
        bit_r <= 4'h0;
        ack_ok_r <= (state_r != tws_pkg::ST_DEV) || dev_ack;
        if (state_r == tws_pkg::ST_ADDR_HI) begin
          addr_r[14:8] <= word_in[6:0];
        end
        if (state_r == tws_pkg::ST_ADDR_LO) begin
          addr_r[7:0] <= word_in;
        end
        if (state_r == tws_pkg::ST_DATA && !wp_r) begin
          wrote_r <= 1'b1;
        end
      end
      if (evt.fall && ack_phase_r && bit_r == 4'h0) begin
        bit_r <= 4'h1;
      end
      if (ack_end) begin
        ack_phase_r <= 1'b0;
        ack_ok_r <= 1'b0;
        bit_r <= 4'h0;
      end
      if (wr_r.valid) begin
        addr_r <= addr_next;
      end
    end
  end

  // ==========================================================================
  // Array write strobe, program timer and acknowledge driver
  // ==========================================================================
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wr_r <= '0;
      busy_r <= 1'b0;
      prog_cnt_r <= 32'h0;
      sda_oe_r <= 1'b0;
      standby_r <= 1'b1;
      sda_out_r <= 1'b0;
    end else begin
      wr_r.valid <= word_done && state_r == tws_pkg::ST_DATA && !wp_r
                    && !evt.start && !evt.stop;
      wr_r.addr <= addr_r;
      wr_r.data <= word_in;
      standby_r <= (state_r == tws_pkg::ST_IDLE) && !busy_r;
      sda_out_r <= 1'b0;
      if (evt.stop && wrote_r && !busy_r) begin
        busy_r <= 1'b1;
        prog_cnt_r <= 32'h0;
      end else if (prog_done) begin
        busy_r <= 1'b0;
      end else if (busy_r) begin
        prog_cnt_r <= prog_cnt_r + 32'h1;
      end
      if (evt.start || evt.stop) begin
        sda_oe_r <= 1'b0;
      end else if (evt.fall) begin
        sda_oe_r <= ack_phase_r && ack_ok_r && bit_r == 4'h0;
      end else if (ack_end) begin
        sda_oe_r <= 1'b0;
      end
    end
  end

  assign o_sda_oe = sda_oe_r;
  assign o_sda_out = sda_out_r;
  assign o_mem_wr = wr_r;
  assign o_busy = busy_r;
  assign o_standby = standby_r;

endmodule : tws_slave

// ==== tws_slave_checker.sv ====
// Port checker for the two-wire EEPROM write slave.
`timescale 1ns/1ps
module tws_slave_checker #(
  parameter int unsigned PROG_CYCLES = tws_pkg::PROG_CYCLES,
  parameter int unsigned PAGE_BYTES = 64
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic o_sda_oe,
  input wire logic o_sda_out,
  input wire logic i_chip_select_pin_high,
  input wire logic i_chip_select_pin_mid,
  input wire logic i_chip_select_pin_low,
  input wire logic i_write_protect,
  input wire tws_pkg::tws_wr_t o_mem_wr,
  input wire logic o_busy,
  input wire logic o_standby
);
  logic [31:0] busy_cnt_r;
  logic [14:0] last_addr_r;
  logic in_page_r;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      busy_cnt_r <= 32'h0;
      last_addr_r <= 15'h0;
      in_page_r <= 1'b0;
    end else begin
      busy_cnt_r <= o_busy ? busy_cnt_r + 32'h1 : 32'h0;
      if (o_mem_wr.valid) last_addr_r <= o_mem_wr.addr;
      in_page_r <= o_mem_wr.valid | (in_page_r & ~o_busy & ~o_standby);
    end
  end
  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  ack_held_a: assert property ($rose(o_sda_oe) |-> o_sda_oe[*8])
    else $error("acknowledge dropped early");
  open_drain_a: assert property (o_sda_out == 1'b0)
    else $error("data output value not zero");
  reset_standby_a: assert property (!$past(i_rstn) |-> o_standby)
    else $error("no standby after reset");
  standby_quiet_a: assert property (
    o_standby |-> !o_busy && !o_sda_oe) else $error("standby not quiet");
  busy_no_ack_a: assert property (o_busy |-> !o_sda_oe)
    else $error("acknowledge while programming");
  prog_time_a: assert property (
    $fell(o_busy) |-> busy_cnt_r == PROG_CYCLES)
    else $error("program time wrong");
  wp_no_write_a: assert property (
    i_write_protect && $past(i_write_protect, 4) |-> !o_mem_wr.valid)
    else $error("array write while protected");
  wp_no_prog_a: assert property ($rose(o_busy) |-> !i_write_protect)
    else $error("program started while protected");
  wr_pulse_a: assert property (o_mem_wr.valid |=> !o_mem_wr.valid)
    else $error("write pulse longer than one cycle");
  page_wrap_a: assert property (
    o_mem_wr.valid && in_page_r |->
      o_mem_wr.addr == {last_addr_r[14:6], last_addr_r[5:0] + 6'h1})
    else $error("page address step wrong");
  cover property (o_mem_wr.valid);
  cover property ($rose(o_busy));
  cover property ($rose(o_sda_oe));
endmodule : tws_slave_checker

bind tws_slave tws_slave_checker #(.PROG_CYCLES(PROG_CYCLES),
  .PAGE_BYTES(PAGE_BYTES)) u_chk (.i_clk(i_clk), .i_rstn(i_rstn),
  .i_scl(i_scl), .i_sda(i_sda), .o_sda_oe(o_sda_oe), .o_sda_out(o_sda_out),
  .i_chip_select_pin_high(i_chip_select_pin_high),
  .i_chip_select_pin_mid(i_chip_select_pin_mid),
  .i_chip_select_pin_low(i_chip_select_pin_low),
  .i_write_protect(i_write_protect), .o_mem_wr(o_mem_wr),
  .o_busy(o_busy), .o_standby(o_standby));

// ==== tws_ctrl_model.sv ====
// Behavioural two-wire bus controller that drives the serial clock.
`timescale 1ns/1ps
module tws_ctrl_model #(
  parameter int Q = 60
) (
  output logic o_scl,
  output logic o_sda_low,
  input wire logic i_sda
);
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end
  task automatic start();
    #(Q) o_sda_low = 1'b0;
    #(Q) o_scl = 1'b1;
    #(Q) o_sda_low = 1'b1;
    #(2*Q) o_scl = 1'b0;
  endtask : start
  task automatic stop();
    #(Q) o_sda_low = 1'b1;
    #(Q) o_scl = 1'b1;
    #(Q) o_sda_low = 1'b0;
    #(2*Q);
  endtask : stop
  task automatic bit_out(input logic b, output logic seen);
    #(Q) o_sda_low = ~b;
    #(Q) o_scl = 1'b1;
    #(Q) seen = (i_sda === 1'b0);
    #(Q) o_scl = 1'b0;
  endtask : bit_out
  task automatic put_byte(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--) bit_out(d[i], ack);
    bit_out(1'b1, ack);
  endtask : put_byte
  task automatic clk_n(input int n);
    logic s;
    for (int i = 0; i < n; i++) bit_out(1'b1, s);
  endtask : clk_n
endmodule : tws_ctrl_model

// ==== tb_two_wire_eeprom_write_slave.sv ====
// Self-checking testbench for the two-wire EEPROM write slave.
`timescale 1ns/1ps
module tb_two_wire_eeprom_write_slave;
  localparam int unsigned PROG = 600;
  logic i_clk, i_rstn, wp, sda_oe, sda_out, busy, stby, scl, ctl_low;
  logic [2:0] strap;
  logic rec_ack;
  logic [15:0] wa;
  int seed, fail_count, n_compared;
  tws_pkg::tws_wr_t mem_wr;
  tws_pkg::tws_wr_t got[$];
  tws_pkg::tws_wr_t exp[$];
  wire sda = !(ctl_low || (sda_oe && !sda_out));
  tws_ctrl_model u_ctl (.o_scl(scl), .o_sda_low(ctl_low), .i_sda(sda));
  tws_slave #(.PROG_CYCLES(PROG)) i_dut (.i_clk(i_clk), .i_rstn(i_rstn),
    .i_scl(scl), .i_sda(sda), .o_sda_oe(sda_oe), .o_sda_out(sda_out),
    .i_chip_select_pin_high(strap[2]), .i_chip_select_pin_mid(strap[1]),
    .i_chip_select_pin_low(strap[0]), .i_write_protect(wp),
    .o_mem_wr(mem_wr), .o_busy(busy), .o_standby(stby));
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end
  always @(posedge i_clk) if (mem_wr.valid === 1'b1) got.push_back(mem_wr);
  // ==========================================================================
  // Helpers
  // ==========================================================================
  function automatic logic [14:0] exp_addr(input logic [14:0] a, input int i);
    return {a[14:6], a[5:0] + 6'(i)};
  endfunction : exp_addr
  task automatic check(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : check
  task automatic txn(input logic [7:0] dev, input int n, input logic ack_e);
    logic a;
    logic [7:0] d;
    u_ctl.start();
    u_ctl.put_byte(dev, a);
    check("dev_ack", ack_e, a);
    if (n >= 0 && a) begin
      u_ctl.put_byte(wa[15:8], a);
      check("addr_hi_ack", 1, a);
      u_ctl.put_byte(wa[7:0], a);
      check("addr_lo_ack", 1, a);
      for (int i = 0; i < n; i++) begin
        d = 8'($random(seed));
        if (!wp) exp.push_back({1'b1, exp_addr(wa[14:0], i), d});
        u_ctl.put_byte(d, a);
        check("data_ack", 1, a);
      end
    end
    u_ctl.stop();
    repeat (20) @(posedge i_clk);
    #1;
  endtask : txn
  task automatic cmp_wr();
    check("wr_count", exp.size(), got.size());
    while (exp.size() > 0 && got.size() > 0)
      check("mem_wr", exp.pop_front(), got.pop_front());
    exp.delete();
    got.delete();
  endtask : cmp_wr
  task automatic wait_idle();
    for (int i = 0; i < 2000 && busy !== 1'b0; i++) @(posedge i_clk);
    #1;
    check("busy_end", 0, busy);
  endtask : wait_idle
  task automatic print_verdict();
    if (fail_count == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  // ==========================================================================
  // Scenarios
  // ==========================================================================
  initial begin
    seed = 32'h5e50;
    i_rstn = 1'b0;
    wp = 1'b0;
    wa = 16'h0;
    strap = 3'($random(seed));
    repeat (8) @(posedge i_clk);
    #1 i_rstn = 1'b1;
    repeat (10) @(posedge i_clk);
    #1;
    u_ctl.start();
    u_ctl.put_byte({4'ha, strap, 1'b0}, rec_ack);
    check("rec_ack", 1, rec_ack);
    u_ctl.clk_n(3);
    repeat (20) @(posedge i_clk);
    #1;
    check("standby_mid", 0, stby);
    u_ctl.start();
    u_ctl.clk_n(9);
    u_ctl.start();
    u_ctl.stop();
    repeat (20) @(posedge i_clk);
    #1;
    check("standby_rec", 1, stby);
    for (int k = 0; k < 8; k++)
      txn({4'ha, 3'(k), 1'b0}, -1, k == strap);
    txn({4'h5, strap, 1'b0}, -1, 0);
    wa = 16'($random(seed));
    txn({4'ha, strap, 1'b0}, 1, 1);
    check("busy", 1, busy);
    txn({4'ha, strap, 1'b0}, -1, 0);
    wait_idle();
    txn({4'ha, strap, 1'b0}, -1, 1);
    cmp_wr();
    wa = {1'b1, 9'($random(seed)), 6'h3e};
    txn({4'ha, strap, 1'b0}, 66, 1);
    cmp_wr();
    wait_idle();
    @(posedge i_clk);
    #1 wp = 1'b1;
    wa = 16'($random(seed));
    txn({4'ha, strap, 1'b0}, 3, 1);
    check("wp_busy", 0, busy);
    cmp_wr();
    @(posedge i_clk);
    #1 wp = 1'b0;
    txn({4'ha, strap, 1'b1}, -1, 1);
    check("read_standby", 1, stby);
    print_verdict();
  end
  initial begin
    repeat (60000) @(posedge i_clk);
    fail_count++;
    print_verdict();
  end
endmodule : tb_two_wire_eeprom_write_slave
